// >>> logic/odp_decoder.sv
// partial instruction decoder with axi4-lite register access
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module odp_decoder
  import odp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control bits
  output logic [CB_W-1:0] control_bits,
  output logic external_flag_output
);
  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [CB_W-1:0] setb_mask(input logic [3:0] n);
    logic [CB_W-1:0] m;
    m = '0;
    if (n == SC_CARRY) m[CB_CARRY] = 1'b1;
    else if (n == SC_CNF) m[CB_CNF] = 1'b1;
    else if (n == SC_INTM) m[CB_INTM] = 1'b1;
    else if (n == SC_OVM) m[CB_OVM] = 1'b1;
    else if (n == SC_TC) m[CB_TC] = 1'b1;
    else if (n == SC_EF) m[CB_EF] = 1'b1;
    else if (n == SC_SXM) m[CB_SXM] = 1'b1;
    return m;
  endfunction

  // the bfa and bfd long-immediate forms share the bf upper byte, so they go first
  function automatic odp_op_type decode_op(input logic [15:0] w);
    logic [7:0] ub;
    odp_op_type op;
    ub = w[15:8];
    op = OP_NONE;
    if (w == OPW_POP) op = OP_POP; // RULE1
    else if (w == OPW_PUSH) op = OP_PUSH; // RULE4
    else if (w == OPW_SPRD) op = OP_SPRD; // RULE20
    else if (w == OPW_XOR16) op = OP_XOR16; // RULE18
    else if (w[15:4] == PFX_SETB && setb_mask(w[3:0]) != '0)
      op = OP_SETB; // RULE9
    else if (w[15:4] == PFX_SUBL) op = OP_SUBL; // RULE14
    else if (w[15:4] == PFX_XORL) op = OP_XORL; // RULE18
    else if (w[15:10] == TOP_CRET) op = OP_CRET; // RULE5
    else if (w[15:12] == NB_SACX)
      op = w[11] ? OP_STAH : OP_STAL; // RULE7
    else if (w[15:12] == NB_SUB) op = OP_SUBM; // RULE15
    else if (ub == UB_POPM) op = OP_POPM; // RULE2
    else if (ub == UB_PSHM) op = OP_PSHM; // RULE3
    else if (ub == UB_RPTM) op = OP_RPTM; // RULE6
    else if (ub == UB_RPTK) op = OP_RPTK; // RULE6
    else if (ub == UB_AUXS) op = OP_AUXS; // RULE8
    else if (ub == UB_PSM) op = OP_PSM; // RULE10
    else if (ub == UB_SQAD) op = OP_SQAD; // RULE11
    else if (ub == UB_SQSB) op = OP_SQSB; // RULE11
    else if (ub == UB_SST0) op = OP_SST0; // RULE12
    else if (ub == UB_SST1) op = OP_SST1; // RULE12
    else if (ub == UB_STLI) op = OP_STLI; // RULE13
    else if (ub == UB_SUBH) op = OP_SUBH; // RULE15
    else if (ub == UB_SUBK) op = OP_SUBK; // RULE15
    else if (ub == UB_SBRW) op = OP_SBRW; // RULE16
    else if (ub == UB_SBCD) op = OP_SBCD; // RULE16
    else if (ub == UB_SBNX) op = OP_SBNX; // RULE17
    else if (ub == UB_SBTS) op = OP_SBTS; // RULE17
    else if (ub == UB_XORM) op = OP_XORM; // RULE18
    else if (ub == UB_ZLRD) op = OP_ZLRD; // RULE19
    return op;
  endfunction

  function automatic logic two_word(input odp_op_type op);
    return op == OP_STLI || op == OP_SUBL || op == OP_XORL ||
           op == OP_XOR16;
  endfunction

  function automatic logic short_imm(input odp_op_type op);
    return op == OP_RPTK || op == OP_AUXS || op == OP_SUBK;
  endfunction

  function automatic logic has_addr(input odp_op_type op);
    return !(short_imm(op) || two_word(op) || op == OP_NONE ||
             op == OP_POP || op == OP_PUSH || op == OP_SPRD ||
             op == OP_CRET || op == OP_SETB) || op == OP_STLI;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  odp_state_type state_reg, state_next;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [PM_AW-1:0] pc_reg;
  logic [3:0] flags_reg;
  logic [CB_W-1:0] ctl_reg;
  logic [15:0] opword_reg, const_reg;
  odp_op_type op_reg;
  logic [1:0] words_reg;
  logic [2:0] cyc_reg, ars_reg;
  logic [3:0] sft_reg;
  logic [7:0] low_reg;
  logic ind_reg, ctp_reg, done_reg, bad_reg;
  logic [15:0] mem_rdata;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire aw_held_next = (aw_held_reg & ~wr_fire) | aw_take;
  wire w_held_next = (w_held_reg & ~wr_fire) | w_take;
  wire bvalid_next = (bvalid_reg & ~s_axi_bready) | wr_fire;
  wire rvalid_next = (rvalid_reg & ~s_axi_rready) | ar_take;
  wire busy = state_reg != S_IDLE;
  wire wr_ctrl = wr_fire && awaddr_reg == OFS_CTRL;
  wire wr_pc = wr_fire && awaddr_reg == OFS_PC;
  wire wr_flags = wr_fire && awaddr_reg == OFS_FLAGS;
  wire wr_status = wr_fire && awaddr_reg == OFS_STATUS;
  wire wr_ctl = wr_fire && awaddr_reg == OFS_CTLBITS;
  wire wr_pm = wr_fire && awaddr_reg[7:6] == PM_WIN_SEL &&
               awaddr_reg[1:0] == 2'h0;
  wire wr_ro = wr_fire && (awaddr_reg == OFS_OPWORD ||
               awaddr_reg == OFS_CONST || awaddr_reg == OFS_RESULT);
  wire wr_ok = wr_ctrl | wr_pc | wr_flags | wr_status | wr_ctl |
               wr_pm | wr_ro;
  wire [31:0] wr_val = merge(32'h0, wdata_reg, wstrb_reg);
  // a start while busy is dropped; software polls busy first
  wire start = wr_ctrl & wr_val[CTRL_START] & ~busy;
  // the memory takes only whole half-words
  wire pm_we = wr_pm & (&wstrb_reg[1:0]);
  wire [31:0] result_word = {ctp_reg, ars_reg, sft_reg, low_reg,
    ind_reg, cyc_reg, 2'h0, words_reg, 3'h0, op_reg};
  wire [31:0] status_word = {29'h0, bad_reg, done_reg, busy};
  wire rd_pm = s_axi_araddr[7:6] == PM_WIN_SEL &&
               s_axi_araddr[1:0] == 2'h0;
  wire [31:0] rd_val =
    s_axi_araddr == OFS_CTRL ? 32'h0 :
    s_axi_araddr == OFS_PC ? {28'h0, pc_reg} :
    s_axi_araddr == OFS_FLAGS ? {28'h0, flags_reg} :
    s_axi_araddr == OFS_STATUS ? status_word :
    s_axi_araddr == OFS_OPWORD ? {16'h0, opword_reg} :
    s_axi_araddr == OFS_CONST ? {16'h0, const_reg} :
    s_axi_araddr == OFS_RESULT ? result_word :
    s_axi_araddr == OFS_CTLBITS ? {25'h0, ctl_reg} : 32'h0;
  wire rd_ok = rd_pm || s_axi_araddr[7:5] == 3'h0 &&
               s_axi_araddr[1:0] == 2'h0;

  // ---------------------------------------------------------------
  // decode of the fetched word
  // ---------------------------------------------------------------
  wire in_decode = state_reg == S_DECODE;
  wire in_imm = state_reg == S_IMM;
  wire odp_op_type dec_op = decode_op(mem_rdata);
  wire dec_two = two_word(dec_op);
  wire dec_addr = has_addr(dec_op);
  // return is taken when every selected condition holds
  wire dec_taken = (flags_reg & mem_rdata[7:4]) == mem_rdata[7:4];
  wire [2:0] dec_cyc =
    dec_op == OP_NONE ? 3'h0 :
    dec_op == OP_CRET ? (dec_taken ? CYC_RET_TAKEN : CYC_RET_SKIP) :
    dec_two ? CYC_TWO : CYC_ONE; // RULE5 RULE13 RULE14 RULE18
  wire [3:0] dec_sft =
    (dec_op == OP_STAH || dec_op == OP_STAL) ?
      {1'b0, mem_rdata[10:8]} : // RULE7
    dec_op == OP_SUBM ? mem_rdata[11:8] : // RULE15
    (dec_op == OP_SUBL || dec_op == OP_XORL) ?
      mem_rdata[3:0] : 4'h0; // RULE14 RULE18
  wire [CB_W-1:0] dec_set =
    (in_decode && dec_op == OP_SETB) ? setb_mask(mem_rdata[3:0]) : '0;
  wire finish = (in_decode & ~dec_two) | in_imm;
  wire [PM_AW-1:0] mem_raddr = in_decode ? PM_AW'(pc_reg + 1'b1) :
                               pc_reg; // RULE22

  odp_prog_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(pm_we),
    .wr_addr(awaddr_reg[PM_AW+1:2]),
    .wr_data(wdata_reg[15:0]),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (start) state_next = S_FETCH;
      S_FETCH: state_next = S_DECODE;
      S_DECODE: state_next = dec_two ? S_IMM : S_IDLE; // RULE22
      S_IMM: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // bus channels
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      awready_reg <= ~aw_held_next;
      wready_reg <= ~w_held_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      if (wr_fire) bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) rdata_reg <= rd_ok ? rd_val : 32'h0;
      if (ar_take) rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // sequencer and decoded results
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      pc_reg <= RST_PC;
      flags_reg <= RST_FLAGS;
      ctl_reg <= RST_CTL;
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
      opword_reg <= 16'h0;
      const_reg <= 16'h0;
      op_reg <= OP_NONE;
      words_reg <= 2'h0;
      cyc_reg <= 3'h0;
      sft_reg <= 4'h0;
      low_reg <= 8'h0;
      ind_reg <= 1'b0;
      ars_reg <= 3'h0;
      ctp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_flags) flags_reg <= wr_val[3:0];
      // a set from the decoder wins over a software write
      ctl_reg <= (wr_ctl ? wr_val[CB_W-1:0] : ctl_reg) | dec_set; // RULE9
      done_reg <= finish | (done_reg & ~start &
                  ~(wr_status & wr_val[ST_DONE]));
      if (wr_pc && !busy) pc_reg <= wr_val[PM_AW-1:0];
      // one step per fetched word, so two-word forms end two ahead
      else if (in_decode | in_imm) pc_reg <= PM_AW'(pc_reg + 1'b1); // RULE22
      if (in_imm) const_reg <= mem_rdata; // RULE13 RULE22
      if (in_decode)
      begin
        opword_reg <= mem_rdata;
        op_reg <= dec_op;
        bad_reg <= dec_op == OP_NONE;
        words_reg <= dec_op == OP_NONE ? 2'h0 : dec_two ? 2'h2 : 2'h1;
        cyc_reg <= dec_cyc;
        sft_reg <= dec_sft;
        low_reg <= mem_rdata[7:0]; // RULE21
        ind_reg <= dec_addr & mem_rdata[7]; // RULE21
        ars_reg <= dec_addr & mem_rdata[7] ? mem_rdata[2:0] : 3'h0;
        ctp_reg <= dec_op == OP_CRET ? mem_rdata[8] : 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign control_bits = ctl_reg;
  assign external_flag_output = ctl_reg[CB_EF];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_dec_word(logic [15:0] w);
    in_decode && mem_rdata == w;
  endsequence
  sequence s_two_fetch;
    in_decode && dec_two ##1 in_imm;
  endsequence

  chk_pop_low_acc: assert property ( // RULE1
    s_dec_word(OPW_POP) |=> op_reg == OP_POP && words_reg == 2'h1 &&
      cyc_reg == CYC_ONE) else $error("pop decode wrong");
  chk_ret_four: assert property ( // RULE5
    s_dec_word(OPW_RET) |=> op_reg == OP_CRET &&
      cyc_reg == CYC_RET_TAKEN) else $error("return cycles wrong");
  chk_store_half: assert property ( // RULE7
    in_decode && mem_rdata[15:12] == NB_SACX |=>
      op_reg == ($past(mem_rdata[11]) ? OP_STAH : OP_STAL) &&
      sft_reg == {1'b0, $past(mem_rdata[10:8])})
    else $error("store half decode wrong");
  chk_aux_sub_imm: assert property ( // RULE8
    in_decode && mem_rdata[15:8] == UB_AUXS |=>
      op_reg == OP_AUXS && low_reg == $past(mem_rdata[7:0]) &&
      !ind_reg) else $error("aux subtract decode wrong");
  chk_flag_set: assert property ( // RULE9
    s_dec_word({PFX_SETB, SC_EF}) |=> external_flag_output)
    else $error("flag output not set");
  chk_store_long_imm: assert property ( // RULE13
    in_decode && mem_rdata[15:8] == UB_STLI |=>
      in_imm && op_reg == OP_STLI && cyc_reg == CYC_TWO ##1
      const_reg == $past(mem_rdata)) else $error("constant fetch wrong");
  chk_sub_long_shift: assert property ( // RULE14
    in_decode && mem_rdata[15:4] == PFX_SUBL |=>
      op_reg == OP_SUBL && sft_reg == $past(mem_rdata[3:0]) &&
      words_reg == 2'h2) else $error("long subtract decode wrong");
  chk_xor_sixteen: assert property ( // RULE18
    s_dec_word(OPW_XOR16) |=> op_reg == OP_XOR16 && words_reg == 2'h2)
    else $error("xor shift sixteen decode wrong");
  chk_pc_plus_two: assert property ( // RULE22
    s_two_fetch |=> state_reg == S_IDLE && done_reg &&
      pc_reg == PM_AW'($past(pc_reg, 2) + 2'h2))
    else $error("pc not advanced by two");
  chk_one_word_done: assert property ( // RULE20
    s_dec_word(OPW_SPRD) |=> state_reg == S_IDLE && done_reg &&
      op_reg == OP_SPRD && pc_reg == PM_AW'($past(pc_reg) + 1'b1))
    else $error("product subtract step wrong");
endmodule // odp_decoder

// >>> logic/odp_pkg.sv
// constants and types for the partial instruction decoder
//
// Overview of operation
// [RULE1] word be32: pop stack to low accumulator
// [RULE2] upper byte 8a: pop stack to memory
// [RULE3] upper byte 76: push memory onto stack
// [RULE4] word be3c: push low accumulator
// [RULE5] top six 111011: conditional return, 4/2 cycles
// [RULE6] repeat from memory 0b or immediate bb
// [RULE7] nibble 9: store accumulator half, 3-bit shift
// [RULE8] upper byte 7c: aux register minus immediate
// [RULE9] be4x sets one selected control bit
// [RULE10] upper byte bf: product shift mode
// [RULE11] 52 square-add, 53 square-subtract
// [RULE12] 8e/8f store status zero/one
// [RULE13] ae stores next word constant, 2/2
// [RULE14] bfa with shift: subtract long constant
// [RULE15] subtract forms 3x, 65, ba
// [RULE16] 64 subtract borrow, 0a conditional subtract
// [RULE17] 66 no sign-extend, 67 temp-register shift
// [RULE18] exclusive-or 6c, bfd, be83 forms
// [RULE19] 68: zero low, load high, round
// [RULE20] word be05: subtract product register
// [RULE21] low byte is address or short constant
// [RULE22] two-word forms fetch constant, pc plus two
package odp_pkg;
  typedef logic [4:0] odp_op_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FETCH = 4'b0010,
    S_DECODE = 4'b0100,
    S_IMM = 4'b1000
  } odp_state_type;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_OPWORD = 8'h10;
  localparam logic [7:0] OFS_CONST = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_CTLBITS = 8'h1c;
  localparam logic [1:0] PM_WIN_SEL = 2'h1;
  localparam int PM_AW = 4;
  localparam int PM_DEPTH = 16;
  // field positions
  localparam int CTRL_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_BAD = 2;
  localparam int RES_OP_LSB = 0;
  localparam int RES_WORDS_LSB = 8;
  localparam int RES_CYC_LSB = 12;
  localparam int RES_IND_BIT = 15;
  localparam int RES_LOW_LSB = 16;
  localparam int RES_SFT_LSB = 24;
  localparam int RES_ARS_LSB = 28;
  localparam int RES_CTP_LSB = 31;
  localparam int CB_CARRY = 0;
  localparam int CB_CNF = 1;
  localparam int CB_INTM = 2;
  localparam int CB_OVM = 3;
  localparam int CB_TC = 4;
  localparam int CB_EF = 5;
  localparam int CB_SXM = 6;
  localparam int CB_W = 7;
  // reset values
  localparam logic [PM_AW-1:0] RST_PC = 4'h0;
  localparam logic [CB_W-1:0] RST_CTL = 7'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // encodings
  localparam logic [15:0] OPW_POP = 16'hbe32;
  localparam logic [15:0] OPW_PUSH = 16'hbe3c;
  localparam logic [15:0] OPW_SPRD = 16'hbe05;
  localparam logic [15:0] OPW_XOR16 = 16'hbe83;
  localparam logic [15:0] OPW_RET = 16'hef00;
  localparam logic [11:0] PFX_SETB = 12'hbe4;
  localparam logic [11:0] PFX_SUBL = 12'hbfa;
  localparam logic [11:0] PFX_XORL = 12'hbfd;
  localparam logic [5:0] TOP_CRET = 6'h3b;
  localparam logic [3:0] NB_SACX = 4'h9;
  localparam logic [3:0] NB_SUB = 4'h3;
  localparam logic [7:0] UB_POPM = 8'h8a;
  localparam logic [7:0] UB_PSHM = 8'h76;
  localparam logic [7:0] UB_RPTM = 8'h0b;
  localparam logic [7:0] UB_RPTK = 8'hbb;
  localparam logic [7:0] UB_AUXS = 8'h7c;
  localparam logic [7:0] UB_PSM = 8'hbf;
  localparam logic [7:0] UB_SQAD = 8'h52;
  localparam logic [7:0] UB_SQSB = 8'h53;
  localparam logic [7:0] UB_SST0 = 8'h8e;
  localparam logic [7:0] UB_SST1 = 8'h8f;
  localparam logic [7:0] UB_STLI = 8'hae;
  localparam logic [7:0] UB_SUBH = 8'h65;
  localparam logic [7:0] UB_SUBK = 8'hba;
  localparam logic [7:0] UB_SBRW = 8'h64;
  localparam logic [7:0] UB_SBCD = 8'h0a;
  localparam logic [7:0] UB_SBNX = 8'h66;
  localparam logic [7:0] UB_SBTS = 8'h67;
  localparam logic [7:0] UB_XORM = 8'h6c;
  localparam logic [7:0] UB_ZLRD = 8'h68;
  localparam logic [3:0] SC_CARRY = 4'hf;
  localparam logic [3:0] SC_CNF = 4'h5;
  localparam logic [3:0] SC_INTM = 4'h1;
  localparam logic [3:0] SC_OVM = 4'h3;
  localparam logic [3:0] SC_TC = 4'hb;
  localparam logic [3:0] SC_EF = 4'hd;
  localparam logic [3:0] SC_SXM = 4'h7;
  // cycle counts
  localparam logic [2:0] CYC_RET_TAKEN = 3'h4;
  localparam logic [2:0] CYC_RET_SKIP = 3'h2;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  // decoded operation codes
  localparam odp_op_type OP_NONE = 5'h00;
  localparam odp_op_type OP_POP = 5'h01;
  localparam odp_op_type OP_POPM = 5'h02;
  localparam odp_op_type OP_PSHM = 5'h03;
  localparam odp_op_type OP_PUSH = 5'h04;
  localparam odp_op_type OP_CRET = 5'h05;
  localparam odp_op_type OP_RPTM = 5'h06;
  localparam odp_op_type OP_RPTK = 5'h07;
  localparam odp_op_type OP_STAH = 5'h08;
  localparam odp_op_type OP_STAL = 5'h09;
  localparam odp_op_type OP_AUXS = 5'h0a;
  localparam odp_op_type OP_SETB = 5'h0b;
  localparam odp_op_type OP_PSM = 5'h0c;
  localparam odp_op_type OP_SQAD = 5'h0d;
  localparam odp_op_type OP_SQSB = 5'h0e;
  localparam odp_op_type OP_SST0 = 5'h0f;
  localparam odp_op_type OP_SST1 = 5'h10;
  localparam odp_op_type OP_STLI = 5'h11;
  localparam odp_op_type OP_SUBL = 5'h12;
  localparam odp_op_type OP_SUBM = 5'h13;
  localparam odp_op_type OP_SUBH = 5'h14;
  localparam odp_op_type OP_SUBK = 5'h15;
  localparam odp_op_type OP_SBRW = 5'h16;
  localparam odp_op_type OP_SBCD = 5'h17;
  localparam odp_op_type OP_SBNX = 5'h18;
  localparam odp_op_type OP_SBTS = 5'h19;
  localparam odp_op_type OP_XORM = 5'h1a;
  localparam odp_op_type OP_XORL = 5'h1b;
  localparam odp_op_type OP_XOR16 = 5'h1c;
  localparam odp_op_type OP_ZLRD = 5'h1d;
  localparam odp_op_type OP_SPRD = 5'h1e;
endpackage

// >>> logic/odp_prog_mem.sv
// small program memory with registered read data
`timescale 1ns/100ps
module odp_prog_mem
  import odp_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // write side
  input wire logic wr_en,
  input wire logic [PM_AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read side
  input wire logic [PM_AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [PM_DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // odp_prog_mem

// >>> tb/odp_prog_model.sv
// program image model: instruction words and trailing constants
`timescale 1ns/100ps
module odp_prog_model
(
  // case select
  input wire logic [5:0] idx,
  // instruction word and second word
  output logic [15:0] instr,
  output logic [15:0] cword
);
  localparam logic [15:0] IMG [38] = '{
    16'hbe32, 16'h8a85, 16'h7612, 16'hbe3c, 16'hef00, 16'hecf0,
    16'h0b34, 16'hbb7f, 16'h9c34, 16'h9434, 16'h7c05, 16'hbf80,
    16'h5210, 16'h5310, 16'h8e10, 16'h8f10, 16'hae10, 16'hbfa3,
    16'h3210, 16'h6510, 16'hba10, 16'h6410, 16'h0a10, 16'h6610,
    16'h6710, 16'h6c10, 16'hbfd3, 16'hbe83, 16'h6810, 16'hbe05,
    16'hbe4f, 16'hbe45, 16'hbe41, 16'hbe43, 16'hbe4b, 16'hbe4d,
    16'hbe47, 16'hbe40};
  assign instr = IMG[idx];
  // constant differs per case so a stale second word shows up
  assign cword = {idx, 10'h2a5} ^ 16'h0f0f;
endmodule // odp_prog_model

// >>> tb/tb_top.sv
// self-checking bench: decodes a table of words over the register bus
`timescale 1ns/100ps
module tb_top;
  import odp_pkg::*;
  // ----
  // bench signals
  // ----
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, res;
  logic [CB_W-1:0] control_bits;
  logic external_flag_output;
  logic [5:0] idx = 6'h0;
  logic [15:0] instr, cword, got;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  // op code, words, cycles per case
  localparam logic [15:0] EXP_TAB [38] = '{
    16'h0111, 16'h0211, 16'h0311, 16'h0411, 16'h0514, 16'h0512,
    16'h0611, 16'h0711, 16'h0811, 16'h0911, 16'h0a11, 16'h0c11,
    16'h0d11, 16'h0e11, 16'h0f11, 16'h1011, 16'h1122, 16'h1222,
    16'h1311, 16'h1411, 16'h1511, 16'h1611, 16'h1711, 16'h1811,
    16'h1911, 16'h1a11, 16'h1b22, 16'h1c22, 16'h1d11, 16'h1e11,
    16'h0b11, 16'h0b11, 16'h0b11, 16'h0b11, 16'h0b11, 16'h0b11,
    16'h0b11, 16'h0000};

  odp_decoder u_odp_decoder (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .control_bits, .external_flag_output);
  odp_prog_model u_odp_prog_model (.idx, .instr, .cword);

  always #50 clk_sys = ~clk_sys;

  // ----
  // bus tasks
  // ----
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // an idle edge first keeps valid from being lowered and raised at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    axi_rd(a);
    check(n, rd, e);
  endtask

  // load both words, clear done, start, poll for done, fetch result
  task automatic run();
    axi_wr(8'h40, {16'h0, instr});
    axi_wr(8'h44, {16'h0, cword});
    axi_wr(OFS_PC, 32'h0);
    axi_wr(OFS_STATUS, 32'h2);
    axi_wr(OFS_CTRL, 32'h1);
    rd = 32'h0;
    for (int k = 0; k < 20 && !rd[ST_DONE]; k++)
      axi_rd(OFS_STATUS);
    axi_rd(OFS_RESULT);
    res = rd;
    got = {3'h0, res[4:0], 2'h0, res[9:8], 1'h0, res[14:12]};
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 10000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ----
  // test sequence
  // ----
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    rchk("ctl_rst", OFS_CTLBITS, 32'h0);
    rchk("pc_rst", OFS_PC, 32'h0);
    for (int i = 0; i < 38; i++)
    begin
      idx = i[5:0];
      #1;
      run();
      if (i < 8)
        check("dec", got, EXP_TAB[i]);
      else if (i < 18)
        check("dec", got, EXP_TAB[i]);
      else if (i < 30)
        check("dec", got, EXP_TAB[i]);
      else
        check("dec", got, EXP_TAB[i]);
      if (i == 1)
        check("ind", {17'h0, res[30:28], 3'h0, res[15], res[23:16]}, 32'h5185);
      if (i == 7)
        check("imm", {24'h0, res[23:16]}, 32'h7f);
      if (EXP_TAB[i][7:4] == 4'h2)
        rchk("const", OFS_CONST, {16'h0, cword});
      rchk("pc", OFS_PC, (EXP_TAB[i][7:4] == 4'h2) ? 32'h2 : 32'h1);
      if (i >= 30 && i < 37)
        rchk("ctl", OFS_CTLBITS, (32'h2 << (i - 30)) - 32'h1);
    end
    rchk("bad", OFS_STATUS, 32'h6);
    check("flag_out", {31'h0, external_flag_output}, 32'h1);
    check("cbits", {25'h0, control_bits}, 32'h7f);
    axi_wr(OFS_FLAGS, 32'hf);
    check("wr_ok", {30'h0, resp}, 32'h0);
    idx = 6'h05;
    #1;
    run();
    check("ret", {29'h0, res[14:12]}, 32'h4);
    axi_rd(8'h30);
    check("rd_unmap", {rd[29:0], resp}, 32'h2);
    axi_wr(8'h30, 32'h1);
    check("wr_unmap", {30'h0, resp}, 32'h2);
    end_of_test();
  end
endmodule // tb_top
